/* File: rtl/msfu_pkg.sv */
// constants, field layout and carrier types of the metering status flag unit
// ----------------------------------------------------------------------------
// Notes on behaviour
// - three event sources raise interrupt and flags
// - flag logic always runs, no enable
// - each polarity change is a zero-crossing event
// - status bit 11: 1 negative, 0 positive
// - polarity flag follows sign, never written
// - status bit 7 live supply-low indication
// - status bit 6 latched until software clears
// - software writes 0 to clear latched flag
// - cause bits 5:4 read-only, bit 3 writable
// - cause 011 receive reset, 100 software reset
// - config error flag refreshed every 5 ms
// - error 0 only when sum is all ones
// - sum covers calibration, control, reserved, checksum
// - error stays until a passing evaluation
// - clear register bit 6 clears latched flag
// ----------------------------------------------------------------------------
`default_nettype none
package msfu_pkg;
    // ------------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_SYSTEM_STATUS = 10'h0CA;
    localparam logic [IDX_W-1:0] IDX_STATUS_CLEAR = 10'h19D;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h1A0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h1A1;
    localparam logic [IDX_W-1:0] IDX_CAL_FIRST = 10'h0F6;
    localparam logic [IDX_W-1:0] IDX_CAL_LAST = 10'h109;
    localparam logic [IDX_W-1:0] IDX_CONFIG_SUM_WORD = 10'h109;
    localparam logic [IDX_W-1:0] IDX_SYS_CTRL = 10'h180;
    localparam logic [IDX_W-1:0] IDX_ANA_CTRL0 = 10'h182;
    localparam logic [IDX_W-1:0] IDX_ANA_CTRL1 = 10'h183;
    // ------------------------------------------------------------------------
    // checked word store
    // ------------------------------------------------------------------------
    localparam int SLOT_W = 5;
    localparam int SLOT_COUNT = 23;
    localparam logic [SLOT_W-1:0] SLOT_SYS_CTRL = 5'h14;
    localparam logic [SLOT_W-1:0] SLOT_ANA_CTRL0 = 5'h15;
    localparam logic [SLOT_W-1:0] SLOT_ANA_CTRL1 = 5'h16;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h16;
    localparam logic [31:0] SUM_GOOD = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    // ------------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------------
    localparam int BIT_POLARITY = 11;
    localparam int BIT_SUPPLY_LIVE = 7;
    localparam int BIT_SUPPLY_LATCHED = 6;
    localparam int BIT_CAUSE_LO = 3;
    localparam int BIT_CAUSE_HI = 5;
    localparam int BIT_CONFIG_ERR = 2;
    localparam int BIT_CLEAR_SUPPLY = 6;
    localparam int IRQ_W = 3;
    localparam int IRQ_CONFIG = 0;
    localparam int IRQ_ZERO_CROSS = 1;
    localparam int IRQ_SUPPLY = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h7;
    localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;
    // ------------------------------------------------------------------------
    // reset cause codes
    // ------------------------------------------------------------------------
    localparam logic [2:0] CAUSE_RESET = 3'h0;
    localparam logic [2:0] CAUSE_RX = 3'h3;
    localparam logic [2:0] CAUSE_SOFTWARE = 3'h4;
    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam longint CLK_HZ = 20_000_000;
    localparam longint SUM_PERIOD_MS = 5;
    localparam int SUM_PERIOD_CYCLES_DFLT = int'(CLK_HZ * SUM_PERIOD_MS / 1000);
    localparam int PERIOD_CNT_W = 17;
    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic voltage_polarity_flag;
        logic supply_low_live;
        logic supply_low_latched;
        logic [2:0] reset_cause;
        logic config_sum_error;
    } status_fields_t;
    typedef struct packed {
        logic valid;
        logic [SLOT_W-1:0] slot;
    } slot_hit_t;
    typedef enum logic [1:0] {SUM_IDLE, SUM_WALK, SUM_FINISH, SUM_EVAL} sum_state_t;
endpackage : msfu_pkg
`default_nettype wire

/* File: rtl/checked_word_store.sv */
// register store of the checked configuration words, registered read ports
`default_nettype none
module checked_word_store (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [msfu_pkg::SLOT_W-1:0] wr_slot, // write slot
    input wire logic [31:0] wr_data, // write data
    input wire logic [msfu_pkg::SLOT_W-1:0] rd_a_slot, // bus read slot
    output logic [31:0] rd_a_data, // bus read data, one cycle late
    input wire logic [msfu_pkg::SLOT_W-1:0] rd_b_slot, // sum walker read slot
    output logic [31:0] rd_b_data // sum walker read data, one cycle late
);
    logic [31:0] word_ff [msfu_pkg::SLOT_COUNT];

    genvar g;
    generate
        for (g = 0; g < msfu_pkg::SLOT_COUNT; g++) begin : g_word
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    word_ff[g] <= msfu_pkg::WORD_RESET;
                end else if (wr_en && (wr_slot == msfu_pkg::SLOT_W'(g))) begin
                    word_ff[g] <= wr_data;
                end
            end
        end
    endgenerate

    wire logic [31:0] sel_a = (rd_a_slot <= msfu_pkg::SLOT_LAST) ? word_ff[rd_a_slot] : msfu_pkg::WORD_RESET;
    wire logic [31:0] sel_b = (rd_b_slot <= msfu_pkg::SLOT_LAST) ? word_ff[rd_b_slot] : msfu_pkg::WORD_RESET;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_a_data <= msfu_pkg::WORD_RESET;
            rd_b_data <= msfu_pkg::WORD_RESET;
        end else begin
            rd_a_data <= sel_a;
            rd_b_data <= sel_b;
        end
    end
endmodule : checked_word_store
`default_nettype wire

/* File: rtl/metering_status_flag_unit.sv */
// status flags, reset cause, configuration sum check and interrupt with apb slave
`default_nettype none
module metering_status_flag_unit #(
    parameter int SUM_PERIOD_CYCLES = msfu_pkg::SUM_PERIOD_CYCLES_DFLT
) (
    input wire logic clk, // system clock, 20 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction, 1 write
    input wire logic [msfu_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic main_supply_pin_low, // supply comparator, 1 below threshold, async
    input wire logic voltage_negative, // voltage sign, 1 negative, async
    input wire logic rx_reset_seen, // pulse: receive-line reset happened
    input wire logic sw_reset_seen, // pulse: software reset happened
    output logic irq // level interrupt, active high
);
    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------

    // index to slot, reserved included
    function automatic msfu_pkg::slot_hit_t slot_of(input logic [msfu_pkg::IDX_W-1:0] idx);
        msfu_pkg::slot_hit_t h;

        h.valid = 1'b1;
        h.slot = '0;
        if (idx >= msfu_pkg::IDX_CAL_FIRST && idx <= msfu_pkg::IDX_CAL_LAST) begin
            h.slot = msfu_pkg::SLOT_W'(idx - msfu_pkg::IDX_CAL_FIRST);
        end else if (idx == msfu_pkg::IDX_SYS_CTRL) begin
            h.slot = msfu_pkg::SLOT_SYS_CTRL;
        end else if (idx == msfu_pkg::IDX_ANA_CTRL0) begin
            h.slot = msfu_pkg::SLOT_ANA_CTRL0;
        end else if (idx == msfu_pkg::IDX_ANA_CTRL1) begin
            h.slot = msfu_pkg::SLOT_ANA_CTRL1;
        end else begin
            h.valid = 1'b0;
        end

        return h;
    endfunction : slot_of

    // word index, low bits zero
    wire logic [msfu_pkg::IDX_W-1:0] idx = paddr[msfu_pkg::ADDR_W-1:2];
    wire logic aligned = (paddr[1:0] == 2'h0);
    wire msfu_pkg::slot_hit_t bus_hit = slot_of(idx);

    wire logic hit_status = aligned && (idx == msfu_pkg::IDX_SYSTEM_STATUS);
    wire logic hit_clear = aligned && (idx == msfu_pkg::IDX_STATUS_CLEAR);
    wire logic hit_irq_status = aligned && (idx == msfu_pkg::IDX_IRQ_STATUS);
    wire logic hit_irq_mask = aligned && (idx == msfu_pkg::IDX_IRQ_MASK);
    wire logic hit_word = aligned && bus_hit.valid;
    wire logic mapped = hit_status || hit_clear || hit_irq_status || hit_irq_mask || hit_word;

    // ------------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    // one wait state
    wire logic access = psel && penable;
    wire logic first_access = access && !pready_ff;
    wire logic done = access && pready_ff;

    // writes on completing edge
    wire logic wr_ok = done && pwrite && mapped;
    wire logic wr_status = wr_ok && hit_status;
    wire logic wr_clear = wr_ok && hit_clear;
    wire logic wr_irq_status = wr_ok && hit_irq_status;
    wire logic wr_irq_mask = wr_ok && hit_irq_mask;
    wire logic wr_word = wr_ok && hit_word;

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    logic supply_meta_ff;
    logic supply_sync_ff;

    logic sign_meta_ff;
    logic sign_sync_ff;

    // two-stage synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_meta_ff <= 1'b0;
            supply_sync_ff <= 1'b0;
            sign_meta_ff <= 1'b0;
            sign_sync_ff <= 1'b0;
        end else begin
            supply_meta_ff <= main_supply_pin_low;
            supply_sync_ff <= supply_meta_ff;
            sign_meta_ff <= voltage_negative;
            sign_sync_ff <= sign_meta_ff;
        end
    end

    // ------------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------------
    // software-visible flags
    msfu_pkg::status_fields_t status_ff;
    logic config_sum_error_ff;

    // sign edge, both ways
    wire logic zero_cross = sign_sync_ff != status_ff.voltage_polarity_flag;
    wire logic clear_latched = wr_clear && !pwdata[msfu_pkg::BIT_CLEAR_SUPPLY];
    // low supply wins over clear
    wire logic nxt_latched = status_ff.supply_low_live || (status_ff.supply_low_latched && !clear_latched);

    // rx, then sw, then write
    logic [2:0] nxt_reset_cause;
    always_comb begin
        nxt_reset_cause = status_ff.reset_cause;
        if (rx_reset_seen) begin
            nxt_reset_cause = msfu_pkg::CAUSE_RX;
        end else if (sw_reset_seen) begin
            nxt_reset_cause = msfu_pkg::CAUSE_SOFTWARE;
        end else if (wr_status) begin
            nxt_reset_cause = {status_ff.reset_cause[2:1], pwdata[msfu_pkg::BIT_CAUSE_LO]};
        end
    end

    // runs without any enable, as long as clock and power are present
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= '0;
        end else begin
            status_ff.voltage_polarity_flag <= sign_sync_ff;
            status_ff.supply_low_live <= supply_sync_ff;
            status_ff.supply_low_latched <= nxt_latched;
            status_ff.reset_cause <= nxt_reset_cause;
            status_ff.config_sum_error <= config_sum_error_ff;
        end
    end

    // ------------------------------------------------------------------------
    // configuration sum check
    // ------------------------------------------------------------------------
    localparam logic [msfu_pkg::PERIOD_CNT_W-1:0] PERIOD_LAST = msfu_pkg::PERIOD_CNT_W'(SUM_PERIOD_CYCLES - 1);

    logic [msfu_pkg::PERIOD_CNT_W-1:0] period_cnt_ff;
    msfu_pkg::sum_state_t sum_state_ff;
    msfu_pkg::sum_state_t nxt_sum_state;
    logic [msfu_pkg::SLOT_W-1:0] walk_slot_ff;
    logic walk_valid_ff;
    logic [31:0] sum_ff;
    logic [31:0] rd_a_data;
    logic [31:0] rd_b_data;

    wire logic period_tick = period_cnt_ff == PERIOD_LAST;
    // stops at last slot
    wire logic walk_at_last = walk_slot_ff == msfu_pkg::SLOT_LAST;
    wire logic [31:0] nxt_sum = walk_valid_ff ? sum_ff + rd_b_data : sum_ff;

    // idle, walk, drain, evaluate
    always_comb begin
        case (sum_state_ff)
            msfu_pkg::SUM_IDLE: nxt_sum_state = period_tick ? msfu_pkg::SUM_WALK : msfu_pkg::SUM_IDLE;
            msfu_pkg::SUM_WALK: nxt_sum_state = walk_at_last ? msfu_pkg::SUM_FINISH : msfu_pkg::SUM_WALK;
            msfu_pkg::SUM_FINISH: nxt_sum_state = msfu_pkg::SUM_EVAL;
            msfu_pkg::SUM_EVAL: nxt_sum_state = msfu_pkg::SUM_IDLE;
            default: nxt_sum_state = msfu_pkg::SUM_IDLE;
        endcase
    end

    // one tick per period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_cnt_ff <= '0;
        end else begin
            period_cnt_ff <= period_tick ? '0 : period_cnt_ff + 1'b1;
        end
    end

    // every checked word, checksum word included, is added
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_state_ff <= msfu_pkg::SUM_IDLE;
            walk_slot_ff <= '0;
            walk_valid_ff <= 1'b0;
            sum_ff <= msfu_pkg::WORD_RESET;
        end else begin
            sum_state_ff <= nxt_sum_state;
            // read lags slot by one
            walk_valid_ff <= sum_state_ff == msfu_pkg::SUM_WALK;
            if (sum_state_ff == msfu_pkg::SUM_IDLE) begin
                walk_slot_ff <= '0;
                sum_ff <= msfu_pkg::WORD_RESET;
            end else begin
                sum_ff <= nxt_sum;
                if (sum_state_ff == msfu_pkg::SUM_WALK && !walk_at_last) begin
                    walk_slot_ff <= walk_slot_ff + 1'b1;
                end
            end
        end
    end

    // flag only changes at an evaluation, so it holds until a passing one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_sum_error_ff <= 1'b0;
        end else if (sum_state_ff == msfu_pkg::SUM_EVAL) begin
            config_sum_error_ff <= sum_ff != msfu_pkg::SUM_GOOD;
        end
    end

    // a: bus, b: walker
    checked_word_store u_store (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_word),
        .wr_slot(bus_hit.slot),
        .wr_data(pwdata),
        .rd_a_slot(bus_hit.slot),
        .rd_a_data(rd_a_data),
        .rd_b_slot(walk_slot_ff),
        .rd_b_data(rd_b_data)
    );

    // ------------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------------
    // sticky, write one clears
    logic [msfu_pkg::IRQ_W-1:0] irq_status_ff;
    logic [msfu_pkg::IRQ_W-1:0] irq_mask_ff;
    logic irq_ff;

    // levels re-set every cycle
    wire logic [msfu_pkg::IRQ_W-1:0] irq_set = {status_ff.supply_low_latched, zero_cross,
                                                status_ff.config_sum_error};
    wire logic [msfu_pkg::IRQ_W-1:0] irq_clr = wr_irq_status ? pwdata[msfu_pkg::IRQ_W-1:0] : msfu_pkg::IRQ_NONE;
    wire logic [msfu_pkg::IRQ_W-1:0] nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_set;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_ff <= msfu_pkg::IRQ_NONE;
            irq_mask_ff <= msfu_pkg::IRQ_MASK_RESET;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            if (wr_irq_mask) begin
                irq_mask_ff <= pwdata[msfu_pkg::IRQ_W-1:0];
            end
            // from next status, no lag
            irq_ff <= |(nxt_irq_status & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    // unused bits read zero
    logic [31:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[msfu_pkg::BIT_POLARITY] = status_ff.voltage_polarity_flag;
        status_word[msfu_pkg::BIT_SUPPLY_LIVE] = status_ff.supply_low_live;
        status_word[msfu_pkg::BIT_SUPPLY_LATCHED] = status_ff.supply_low_latched;
        status_word[msfu_pkg::BIT_CAUSE_HI:msfu_pkg::BIT_CAUSE_LO] = status_ff.reset_cause;
        status_word[msfu_pkg::BIT_CONFIG_ERR] = status_ff.config_sum_error;
    end

    // reads latched flag back
    wire logic [31:0] clear_word = {25'h0, status_ff.supply_low_latched, 6'h0};

    // unmapped reads zero
    wire logic [31:0] rd_value = hit_status ? status_word :
                                 hit_clear ? clear_word :
                                 hit_irq_status ? {29'h0, irq_status_ff} :
                                 hit_irq_mask ? {29'h0, irq_mask_ff} :
                                 hit_word ? rd_a_data : 32'h00000000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            // one cycle, one wait
            pready_ff <= first_access;
            if (first_access) begin
                pslverr_ff <= !mapped;
                prdata_ff <= pwrite ? 32'h00000000 : rd_value;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // flop outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
endmodule : metering_status_flag_unit
`default_nettype wire

/* File: bench/msfu_chk.sv */
// port-level assertions of the metering status flag unit
`default_nettype none
module msfu_chk #(
    parameter int SUM_PERIOD_CYCLES = 64
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic main_supply_pin_low, // supply comparator
    input wire logic voltage_negative, // voltage sign
    input wire logic rx_reset_seen, // receive reset pulse
    input wire logic sw_reset_seen, // software reset pulse
    input wire logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stability counters of the async inputs
    // ------------------------------------------------------------
    logic [2:0] sup_cnt_ff;
    logic [2:0] pol_cnt_ff;
    logic sup_prev_ff;
    logic pol_prev_ff;
    wire logic [2:0] nxt_sup_cnt = (main_supply_pin_low != sup_prev_ff) ? 3'h0 :
        ((sup_cnt_ff == 3'h7) ? 3'h7 : sup_cnt_ff + 3'h1);
    wire logic [2:0] nxt_pol_cnt = (voltage_negative != pol_prev_ff) ? 3'h0 :
        ((pol_cnt_ff == 3'h7) ? 3'h7 : pol_cnt_ff + 3'h1);
    wire logic done = psel && penable && pready;
    wire logic rd_status = done && !pwrite && (paddr == 12'h328);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sup_prev_ff <= 1'b0;
            pol_prev_ff <= 1'b0;
            sup_cnt_ff <= 3'h0;
            pol_cnt_ff <= 3'h0;
        end else begin
            sup_prev_ff <= main_supply_pin_low;
            pol_prev_ff <= voltage_negative;
            sup_cnt_ff <= nxt_sup_cnt;
            pol_cnt_ff <= nxt_pol_cnt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    property p_ready_wait; (psel && !penable) |=> s_one_wait; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_bad_addr; done && (paddr[1:0] != 2'h0 || paddr == 12'h604) |-> pslverr && prdata == 32'h0; endproperty
    property p_write_zero; done && pwrite |-> prdata == 32'h0; endproperty
    property p_supply_read;
        rd_status && sup_cnt_ff == 3'h7 |-> prdata[7] == main_supply_pin_low && (prdata[6] || !main_supply_pin_low);
    endproperty
    property p_pol_read; rd_status && pol_cnt_ff == 3'h7 |-> prdata[11] == voltage_negative; endproperty
    property p_status_zero; rd_status |-> !pslverr && prdata[31:12] == 20'h0 && prdata[10:8] == 3'h0; endproperty
    property p_clear_read;
        done && !pwrite && paddr == 12'h674 |-> prdata[31:7] == 25'h0 && prdata[5:0] == 6'h0;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_bad_addr: assert property (p_bad_addr) else $error("bad address not refused");
    a_write_zero: assert property (p_write_zero) else $error("read data not zero on write");
    a_supply_read: assert property (p_supply_read) else $error("supply flags wrong");
    a_pol_read: assert property (p_pol_read) else $error("polarity flag wrong");
    a_status_zero: assert property (p_status_zero) else $error("status unused bits set");
    a_clear_read: assert property (p_clear_read) else $error("clear register unused bits set");
endmodule : msfu_chk
bind metering_status_flag_unit msfu_chk #(.SUM_PERIOD_CYCLES(SUM_PERIOD_CYCLES)) i_chk (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_supply_pin_low(main_supply_pin_low),
    .voltage_negative(voltage_negative), .rx_reset_seen(rx_reset_seen), .sw_reset_seen(sw_reset_seen), .irq(irq));
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking testbench of the metering status flag unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PERIOD = 64;
    localparam logic [11:0] A_ST = 12'h328;
    localparam logic [11:0] A_CLR = 12'h674;
    localparam logic [11:0] A_IRQ = 12'h680;
    localparam logic [11:0] A_MASK = 12'h684;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, sup, vneg, rx, sw, irq, perr;
    logic pol, live, lat, cfg;
    logic [2:0] cause;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int err_total, n_checks, cyc;
    logic [11:0] w_addr [7] = '{12'h424, 12'h600, 12'h60C, 12'h3E8, 12'h3D8, 12'h608, 12'h3DC};
    logic [31:0] w_data [7] = '{32'hFFFFFFFF, 32'h00000001, 32'hFFFFFFFF, 32'h00000002, 32'hFFFFFFFE,
        32'h00000001, 32'hFFFFFFFF};
    logic w_err [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    metering_status_flag_unit #(.SUM_PERIOD_CYCLES(PERIOD)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_supply_pin_low(sup), .voltage_negative(vneg), .rx_reset_seen(rx),
        .sw_reset_seen(sw), .irq(irq));
    always #25 clk = ~clk;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic chk_st();
        xfer(1'b0, A_ST, 32'h0);
        chk("status", rd, {20'h0, pol, 3'h0, live, lat, cause, cfg, 2'h0});
    endtask : chk_st
    task automatic chk_irq(input logic [31:0] st, input logic exp);
        xfer(1'b0, A_IRQ, 32'h0);
        chk("irq_status", rd, st);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask : chk_irq
    task automatic pulse(input logic is_sw, input logic [2:0] c);
        @(posedge clk);
        rx <= !is_sw;
        sw <= is_sw;
        @(posedge clk);
        rx <= 1'b0;
        sw <= 1'b0;
        cause = c;
    endtask : pulse
    task automatic set_pin(input logic is_pol, input logic v);
        @(posedge clk);
        if (is_pol) vneg <= v;
        else sup <= v;
        repeat (10) @(posedge clk);
    endtask : set_pin
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {clk, reset_n, psel, penable, pwrite, sup, vneg, rx, sw, paddr, pwdata} = '0;
        {pol, live, lat, cfg, cause, err_total, n_checks, cyc} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        chk_st();
        xfer(1'b0, A_MASK, 32'h0);
        chk("mask", rd, 32'h7);
        chk_irq(32'h0, 1'b0);
        xfer(1'b1, 12'h604, 32'h5);
        chk("unmapped", {31'h0, perr}, 32'h1);
        xfer(1'b0, 12'h329, 32'h0);
        chk("misaligned", {rd[30:0], perr}, 32'h1);
        repeat (PERIOD + 40) @(posedge clk);
        cfg = 1'b1;
        chk_st();
        chk_irq(32'h1, 1'b1);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, w_addr[i], w_data[i]);
            xfer(1'b0, w_addr[i], 32'h0);
            chk("word", rd, w_data[i]);
            repeat (2 * PERIOD + 60) @(posedge clk);
            cfg = w_err[i];
            chk_st();
        end
        xfer(1'b1, A_IRQ, 32'h7);
        chk_irq(32'h0, 1'b0);
        set_pin(1'b0, 1'b1);
        live = 1'b1;
        lat = 1'b1;
        chk_st();
        chk_irq(32'h4, 1'b1);
        set_pin(1'b0, 1'b0);
        live = 1'b0;
        chk_st();
        xfer(1'b1, A_CLR, 32'h40);
        chk_st();
        xfer(1'b0, A_CLR, 32'h0);
        chk("clear_reg", rd, 32'h40);
        xfer(1'b1, A_CLR, 32'h0);
        lat = 1'b0;
        chk_st();
        xfer(1'b1, A_IRQ, 32'h4);
        chk_irq(32'h0, 1'b0);
        set_pin(1'b1, 1'b1);
        pol = 1'b1;
        chk_st();
        chk_irq(32'h2, 1'b1);
        xfer(1'b1, A_ST, 32'hFFFFFFFF);
        cause = 3'h1;
        chk_st();
        xfer(1'b1, A_IRQ, 32'h2);
        xfer(1'b1, A_MASK, 32'h0);
        set_pin(1'b1, 1'b0);
        pol = 1'b0;
        chk_irq(32'h2, 1'b0);
        xfer(1'b1, A_MASK, 32'h7);
        chk_irq(32'h2, 1'b1);
        pulse(1'b0, 3'h3);
        chk_st();
        xfer(1'b1, A_ST, 32'h0);
        cause = 3'h2;
        chk_st();
        pulse(1'b1, 3'h4);
        chk_st();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
